//--- hw/itd_chan.sv
// One channel: hysteresis comparator, polarity, delays and rise counter.
`timescale 1ns/100ps
`default_nettype none
`include "itd_map.svh"

module itd_chan (
  // Clock and reset.
  input  wire logic                sys_clk,
  input  wire logic                rst,
  // Scan evaluation strobe and level.
  input  wire logic                eval,
  input  wire itd_pkg::itd_level_t level_mv,
  // Settings.
  input  wire logic                nc,
  input  wire logic                ac,
  input  wire itd_pkg::itd_thr_t   act_thr,
  input  wire itd_pkg::itd_thr_t   rel_thr,
  input  wire itd_pkg::itd_dly_t   act_dly,
  input  wire itd_pkg::itd_dly_t   drop_dly,
  input  wire logic                clr,
  // Results.
  output logic                     state,
  output logic                     energized,
  output logic [31:0]              count
);

  itd_pkg::itd_ms_t elapsed;
  itd_pkg::itd_ms_t next_elapsed;
  itd_pkg::itd_ms_t hold;
  logic             next_state;
  logic             next_energized;
  logic             want;
  logic [31:0]      next_count;
  logic [22:0]      act_mv;
  logic [22:0]      rel_mv;

  always_comb begin
    act_mv = 23'(act_thr) * `ITD_MV_PER_THR;
    rel_mv = ac ? 23'(act_thr) * `ITD_MV_AC_REL
                : 23'(rel_thr) * `ITD_MV_PER_THR;
    next_energized = energized;
    next_state     = state;
    next_elapsed   = elapsed;
    want           = state;
    hold           = '0;
    if (eval) begin
      // Between the two thresholds the previous level is kept.
      if (23'(level_mv) > act_mv) begin
        next_energized = 1'b1;
      end else if (23'(level_mv) < rel_mv) begin
        next_energized = 1'b0;
      end
      want = next_energized ^ nc;
      hold = want ? 22'(act_dly)
                  : 22'(drop_dly) + (ac ? `ITD_AC_EXTRA_MS : '0);
      if (want == state) begin
        next_elapsed = '0;
      end else if (elapsed >= hold) begin
        next_state   = want;
        next_elapsed = '0;
      end else begin
        next_elapsed = elapsed + `ITD_SCAN_STEP;
      end
    end
    // A rise in the clearing cycle still counts, so no event is lost.
    next_count = (clr ? 32'h0000_0000 : count)
               + {31'h0000_0000, next_state & ~state};
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state     <= 1'b0;
      energized <= 1'b0;
      elapsed   <= '0;
      count     <= 32'h0000_0000;
    end else begin
      state     <= next_state;
      energized <= next_energized;
      elapsed   <= next_elapsed;
      count     <= next_count;
    end
  end

endmodule : itd_chan
`default_nettype wire

//--- hw/itd_map.svh
// Address map, reset values and timing constants of the input conditioner.
`ifndef ITD_MAP_SVH
`define ITD_MAP_SVH

`define ITD_NCH          8
`define ITD_CH_HI        7
`define ITD_CH_LO        5
`define ITD_OFF_CTRL     5'h00
`define ITD_OFF_ACT_THR  5'h04
`define ITD_OFF_REL_THR  5'h08
`define ITD_OFF_ACT_DLY  5'h0C
`define ITD_OFF_DROP_DLY 5'h10
`define ITD_OFF_COUNT    5'h14
`define ITD_OFF_LEVEL    5'h18
`define ITD_OFF_STATE    5'h1C
`define ITD_ADDR_STATES  32'h0000_0100
`define ITD_CTRL_NC      0
`define ITD_CTRL_AC      1
`define ITD_CTRL_CLR     8

`define ITD_ACT_THR_RST  16'h0370
`define ITD_REL_THR_RST  16'h0258
`define ITD_DLY_RST      21'h000000
`define ITD_DLY_MAX      21'h1B7740

`define ITD_CLK_HZ       100000000
`define ITD_SCAN_MS      5
`define ITD_SCAN_CYC     (`ITD_CLK_HZ / 1000 * `ITD_SCAN_MS)
`define ITD_SCAN_STEP    22'h000005
`define ITD_AC_EXTRA_MS  22'h00001E
`define ITD_MV_PER_THR   23'h000064
`define ITD_MV_AC_REL    23'h00000A

`endif

//--- hw/itd_mem.sv
// Level store: one measured level per channel, two registered read ports.
`timescale 1ns/100ps
`default_nettype none
`include "itd_map.svh"

module itd_mem (
  // Clock and reset.
  input  wire logic               sys_clk,
  input  wire logic               rst,
  // Write port.
  input  wire logic               wr_en,
  input  wire logic [2:0]         wr_addr,
  input  wire itd_pkg::itd_level_t wr_data,
  // Read ports.
  input  wire logic [2:0]         rd_a_addr,
  input  wire logic [2:0]         rd_b_addr,
  output itd_pkg::itd_level_t     rd_a_data,
  output itd_pkg::itd_level_t     rd_b_data
);

  itd_pkg::itd_level_t cells [`ITD_NCH];

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      for (int i = 0; i < `ITD_NCH; i++) begin
        cells[i] <= '0;
      end
      rd_a_data <= '0;
      rd_b_data <= '0;
    end else begin
      if (wr_en) begin
        cells[wr_addr] <= wr_data;
      end
      rd_a_data <= cells[rd_a_addr];
      rd_b_data <= cells[rd_b_addr];
    end
  end

endmodule : itd_mem
`default_nettype wire

//--- hw/itd_pkg.sv
// Types shared by the input conditioner modules.
package itd_pkg;

  typedef logic [18:0] itd_level_t;
  typedef logic [15:0] itd_thr_t;
  typedef logic [20:0] itd_dly_t;
  typedef logic [21:0] itd_ms_t;

  typedef enum logic [1:0] {
    ITD_BUS_IDLE = 2'b01,
    ITD_BUS_READ = 2'b10
  } itd_bus_st_t;

endpackage : itd_pkg

//--- hw/itd_top.sv
// Eight-channel input conditioner with an AHB-Lite register slave.
//
// The register offsets and the AHB-Lite interface to the registers were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "itd_map.svh"

// How it works
// - Polarity picks normally-open or normally-closed meaning.
// - Above activation threshold activates; default 88 V.
// - Below release threshold releases; default 60 V.
// - Thresholds are independent for every channel.
// - Programmable delay holds off 0-to-1 changes.
// - Separate programmable delay holds off 1-to-0 changes.
// - AC mode adds 30 ms deactivation delay.
// - AC mode forces release to 10 % activation.
// - Count every reported 0-to-1 change, 32 bits.
// - Clear command zeroes the channel's counter.
// - Measured channel voltage readable in millivolts.
// - Channels evaluated once per 5 ms scan.
// - Eight independent channels, each own logic copy.

module itd_top #(
  parameter int unsigned SCAN_CYCLES = `ITD_SCAN_CYC
) (
  // Clock and reset.
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // AHB-Lite slave.
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Measured levels from the converter logic, in millivolts.
  input  wire logic        sample_valid,
  input  wire logic [2:0]  sample_chan,
  input  wire logic [18:0] sample_mv,
  // Conditioned channel states.
  output logic      [7:0]  input_channel_n
);

  ////////////////////////////////////////////////////////////////////////////

  function automatic logic chan_hit(input logic [31:0] a, input logic [4:0] off);
    chan_hit = (a[31:8] == 24'h00_0000) && (a[4:0] == off);
  endfunction : chan_hit

  ////////////////////////////////////////////////////////////////////////////

  logic [31:0] scan_cnt;
  logic [31:0] next_scan_cnt;
  logic        sweep_on;
  logic        next_sweep_on;
  logic [2:0]  sweep_idx;
  logic [2:0]  next_sweep_idx;
  logic        eval_on;
  logic [2:0]  eval_idx;

  // The level store has one port for the scan, so channels are swept
  // one per clock after each tick; 8 cycles is far below the 5 ms period.
  always_comb begin
    next_scan_cnt  = scan_cnt + 32'h0000_0001;
    next_sweep_on  = sweep_on;
    next_sweep_idx = sweep_idx;
    if (scan_cnt == SCAN_CYCLES - 1) begin
      next_scan_cnt  = 32'h0000_0000;
      next_sweep_on  = 1'b1;
      next_sweep_idx = 3'h0;
    end else if (sweep_on) begin
      next_sweep_idx = sweep_idx + 3'h1;
      if (sweep_idx == 3'h7) begin
        next_sweep_on = 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      scan_cnt  <= 32'h0000_0000;
      sweep_on  <= 1'b0;
      sweep_idx <= 3'h0;
      eval_on   <= 1'b0;
      eval_idx  <= 3'h0;
    end else begin
      scan_cnt  <= next_scan_cnt;
      sweep_on  <= next_sweep_on;
      sweep_idx <= next_sweep_idx;
      eval_on   <= sweep_on;
      eval_idx  <= sweep_idx;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  itd_pkg::itd_level_t lvl_scan;
  itd_pkg::itd_level_t lvl_bus;

  itd_mem u_mem (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .wr_en     (sample_valid),
    .wr_addr   (sample_chan),
    .wr_data   (sample_mv),
    .rd_a_addr (sweep_idx),
    .rd_b_addr (haddr[`ITD_CH_HI:`ITD_CH_LO]),
    .rd_a_data (lvl_scan),
    .rd_b_data (lvl_bus)
  );

  ////////////////////////////////////////////////////////////////////////////

  logic [7:0]        nc;
  logic [7:0]        next_nc;
  logic [7:0]        ac;
  logic [7:0]        next_ac;
  logic [7:0]        clr;
  logic [7:0]        next_clr;
  itd_pkg::itd_thr_t act_thr       [`ITD_NCH];
  itd_pkg::itd_thr_t next_act_thr  [`ITD_NCH];
  itd_pkg::itd_thr_t rel_thr       [`ITD_NCH];
  itd_pkg::itd_thr_t next_rel_thr  [`ITD_NCH];
  itd_pkg::itd_dly_t act_dly       [`ITD_NCH];
  itd_pkg::itd_dly_t next_act_dly  [`ITD_NCH];
  itd_pkg::itd_dly_t drop_dly      [`ITD_NCH];
  itd_pkg::itd_dly_t next_drop_dly [`ITD_NCH];
  logic [7:0]        energized;
  logic [31:0]       count         [`ITD_NCH];

  for (genvar g = 0; g < `ITD_NCH; g++) begin : g_chan
    itd_chan u_chan (
      .sys_clk   (sys_clk),
      .rst       (rst),
      .eval      (eval_on && (eval_idx == 3'(g))),
      .level_mv  (lvl_scan),
      .nc        (nc[g]),
      .ac        (ac[g]),
      .act_thr   (act_thr[g]),
      .rel_thr   (rel_thr[g]),
      .act_dly   (act_dly[g]),
      .drop_dly  (drop_dly[g]),
      .clr       (clr[g]),
      .state     (input_channel_n[g]),
      .energized (energized[g]),
      .count     (count[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////

  itd_pkg::itd_bus_st_t st;
  itd_pkg::itd_bus_st_t next_st;
  logic                 accept;
  logic                 wr_pend;
  logic                 next_wr_pend;
  logic [31:0]          wr_addr;
  logic [31:0]          next_wr_addr;
  logic [31:0]          rd_addr;
  logic [31:0]          next_rd_addr;
  logic [31:0]          next_hrdata;
  logic                 next_hreadyout;
  logic [2:0]           wch;
  logic [2:0]           rch;
  itd_pkg::itd_dly_t    wdly;

  assign accept = hsel && htrans[1] && hready;
  assign wch    = wr_addr[`ITD_CH_HI:`ITD_CH_LO];
  assign rch    = rd_addr[`ITD_CH_HI:`ITD_CH_LO];
  // Delays above the documented range saturate at the longest delay.
  assign wdly   = (hwdata > {11'h000, `ITD_DLY_MAX}) ? `ITD_DLY_MAX : hwdata[20:0];

  always_comb begin
    next_st        = st;
    next_wr_pend   = 1'b0;
    next_wr_addr   = wr_addr;
    next_rd_addr   = rd_addr;
    next_hrdata    = hrdata;
    next_hreadyout = hreadyout;
    case (st)
      itd_pkg::ITD_BUS_IDLE: begin
        if (accept && hwrite) begin
          next_wr_pend = 1'b1;
          next_wr_addr = haddr;
        end else if (accept) begin
          next_rd_addr   = haddr;
          next_hreadyout = 1'b0;
          next_st        = itd_pkg::ITD_BUS_READ;
        end
      end
      itd_pkg::ITD_BUS_READ: begin
        next_hreadyout = 1'b1;
        next_st        = itd_pkg::ITD_BUS_IDLE;
        if (rd_addr == `ITD_ADDR_STATES) begin
          next_hrdata = {24'h00_0000, input_channel_n};
        end else if (chan_hit(rd_addr, `ITD_OFF_CTRL)) begin
          next_hrdata = {30'h0000_0000, ac[rch], nc[rch]};
        end else if (chan_hit(rd_addr, `ITD_OFF_ACT_THR)) begin
          next_hrdata = {16'h0000, act_thr[rch]};
        end else if (chan_hit(rd_addr, `ITD_OFF_REL_THR)) begin
          next_hrdata = {16'h0000, rel_thr[rch]};
        end else if (chan_hit(rd_addr, `ITD_OFF_ACT_DLY)) begin
          next_hrdata = {11'h000, act_dly[rch]};
        end else if (chan_hit(rd_addr, `ITD_OFF_DROP_DLY)) begin
          next_hrdata = {11'h000, drop_dly[rch]};
        end else if (chan_hit(rd_addr, `ITD_OFF_COUNT)) begin
          next_hrdata = count[rch];
        end else if (chan_hit(rd_addr, `ITD_OFF_LEVEL)) begin
          next_hrdata = {13'h0000, lvl_bus};
        end else if (chan_hit(rd_addr, `ITD_OFF_STATE)) begin
          next_hrdata = {30'h0000_0000, energized[rch], input_channel_n[rch]};
        end else begin
          next_hrdata = 32'h0000_0000;
        end
      end
      default: begin
        next_st        = itd_pkg::ITD_BUS_IDLE;
        next_hreadyout = 1'b1;
      end
    endcase
  end

  // Settings writes land in the cycle whose hwdata belongs to them.
  always_comb begin
    next_nc       = nc;
    next_ac       = ac;
    next_clr      = 8'h00;
    next_act_thr  = act_thr;
    next_rel_thr  = rel_thr;
    next_act_dly  = act_dly;
    next_drop_dly = drop_dly;
    if (wr_pend) begin
      if (chan_hit(wr_addr, `ITD_OFF_CTRL)) begin
        next_nc[wch]  = hwdata[`ITD_CTRL_NC];
        next_ac[wch]  = hwdata[`ITD_CTRL_AC];
        next_clr[wch] = hwdata[`ITD_CTRL_CLR];
      end else if (chan_hit(wr_addr, `ITD_OFF_ACT_THR)) begin
        next_act_thr[wch] = hwdata[15:0];
      end else if (chan_hit(wr_addr, `ITD_OFF_REL_THR)) begin
        next_rel_thr[wch] = hwdata[15:0];
      end else if (chan_hit(wr_addr, `ITD_OFF_ACT_DLY)) begin
        next_act_dly[wch] = wdly;
      end else if (chan_hit(wr_addr, `ITD_OFF_DROP_DLY)) begin
        next_drop_dly[wch] = wdly;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st        <= itd_pkg::ITD_BUS_IDLE;
      wr_pend   <= 1'b0;
      wr_addr   <= 32'h0000_0000;
      rd_addr   <= 32'h0000_0000;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      nc        <= 8'h00;
      ac        <= 8'h00;
      clr       <= 8'h00;
      for (int i = 0; i < `ITD_NCH; i++) begin
        act_thr[i]  <= `ITD_ACT_THR_RST;
        rel_thr[i]  <= `ITD_REL_THR_RST;
        act_dly[i]  <= `ITD_DLY_RST;
        drop_dly[i] <= `ITD_DLY_RST;
      end
    end else begin
      st        <= next_st;
      wr_pend   <= next_wr_pend;
      wr_addr   <= next_wr_addr;
      rd_addr   <= next_rd_addr;
      hrdata    <= next_hrdata;
      hreadyout <= next_hreadyout;
      hresp     <= 1'b0;
      nc        <= next_nc;
      ac        <= next_ac;
      clr       <= next_clr;
      act_thr   <= next_act_thr;
      rel_thr   <= next_rel_thr;
      act_dly   <= next_act_dly;
      drop_dly  <= next_drop_dly;
    end
  end

endmodule : itd_top
`default_nettype wire

//--- verif/itd_checker.sv
// Port-level concurrent checks for the eight-channel input conditioner.
`timescale 1ns/100ps
`default_nettype none
`include "itd_map.svh"

module itd_checker #(
  parameter int unsigned SCAN_CYCLES = 32'h7_A120
) (
  // Clock and reset.
  input wire logic        sys_clk,
  input wire logic        rst,
  // Register bus.
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // Channel states.
  input wire logic [7:0]  input_channel_n
);
  wire logic rd_take = hsel && htrans[1] && hready && !hwrite;
  wire logic wr_take = hsel && htrans[1] && hready && hwrite;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  a_reset_idle: assert property (
    $fell(rst) |-> input_channel_n == 8'h00 && hreadyout && hrdata == 32'h0)
    else $error("Outputs not idle after reset.");
  a_read_wait: assert property (
    rd_take |=> !hreadyout ##1 hreadyout)
    else $error("Read did not take exactly one wait state.");
  a_write_nowait: assert property (
    wr_take |=> hreadyout)
    else $error("Write data phase was stalled.");
  a_ready_cause: assert property (
    $fell(hreadyout) |-> $past(rd_take))
    else $error("Wait state without a read.");
  a_resp_okay: assert property (
    hresp == 1'b0)
    else $error("Error response seen.");
  // One change per scan: channel 0 must hold for the 8 cycles after it moves.
  a_scan_hold: assert property (
    $changed(input_channel_n[0]) |=> $stable(input_channel_n[0]) [*8])
    else $error("Channel changed twice within one scan.");
  a_chan_stagger: assert property (
    $changed(input_channel_n[0]) |-> $stable(input_channel_n[7]))
    else $error("Channels evaluated in the same cycle.");
  a_global_read: assert property (
    rd_take && haddr == `ITD_ADDR_STATES ##1 $stable(input_channel_n) [*2]
      |-> hrdata[7:0] == input_channel_n)
    else $error("Global state word differs from channel outputs.");
endmodule : itd_checker

bind itd_top itd_checker #(.SCAN_CYCLES(SCAN_CYCLES)) u_chk (
  .sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
  .hresp(hresp), .input_channel_n(input_channel_n));
`default_nettype wire

//--- verif/itd_field.sv
// Field side model: contacts driving a voltage that the converter samples.
`timescale 1ns/100ps
`default_nettype none

module itd_field (
  // Clock and reset.
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // Measured level stream.
  output var  logic        sample_valid,
  output var  logic [2:0]  sample_chan,
  output var  logic [18:0] sample_mv
);
  int unsigned mv [8];
  logic [2:0]  next_chan;

  initial begin
    sample_valid = 1'b0;
    sample_chan = 3'h0;
    sample_mv = 19'h0;
    next_chan = 3'h0;
  end

  // The converter sweeps the channels one per clock, clipped to its span.
  always @(posedge sys_clk) begin
    if (rst) begin
      sample_valid <= 1'b0;
      sample_mv <= ~sample_mv;
      next_chan <= 3'h0;
    end else begin
      sample_valid <= 1'b1;
      sample_chan <= next_chan;
      sample_mv <= (mv[next_chan] > 32'h4_3238) ? 19'h4_3238 : mv[next_chan][18:0];
      next_chan <= next_chan + 3'h1;
    end
  end
endmodule : itd_field
`default_nettype wire

//--- verif/itd_top_bench.sv
// Self-checking bench for the eight-channel input conditioner.
`timescale 1ns/100ps
`default_nettype none
`include "itd_map.svh"

module itd_top_bench;
  localparam int SCAN = 20;
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  wire  logic [31:0] hrdata;
  wire  logic        hreadyout;
  wire  logic        hresp;
  wire  logic        sample_valid;
  wire  logic [2:0]  sample_chan;
  wire  logic [18:0] sample_mv;
  wire  logic [7:0]  input_channel_n;
  int          n_fail = 0;
  int          cmp_count = 0;
  int          m_lvl[8], m_act[8], m_rel[8], m_nc[8], m_ac[8], m_en[8], m_st[8], m_cnt[8];
  int          lv_sel[5] = '{0, 1, 2, 1, 0};
  logic [31:0] rd;

  always #5 sys_clk = ~sys_clk;

  itd_top #(.SCAN_CYCLES(SCAN)) uut (
    .sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .sample_valid(sample_valid), .sample_chan(sample_chan), .sample_mv(sample_mv),
    .input_channel_n(input_channel_n));

  itd_field fld (
    .sys_clk(sys_clk), .rst(rst), .sample_valid(sample_valid),
    .sample_chan(sample_chan), .sample_mv(sample_mv));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", what, e, g);
    end
  endtask : chk

  function automatic logic [31:0] adr(input int c, input logic [4:0] off);
    return {24'h0, c[2:0], off};
  endfunction : adr

  // The address phase is held until the slave is ready, so a stalled read is never lost.
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus

  task automatic regchk(input int c, input logic [4:0] off, input logic [31:0] e);
    bus(1'b0, adr(c, off), 32'h0);
    chk("register", e, rd);
  endtask : regchk

  task automatic setv(input int c, input int v);
    fld.mv[c] <= v;
    m_lvl[c] = v;
  endtask : setv

  task automatic settle(input int n);
    repeat (n * SCAN) @(posedge sys_clk);
  endtask : settle

  function automatic int hi(input int c);
    return m_act[c] * 32'h64 + 32'h12C;
  endfunction : hi

  task automatic check_all;
    int         ra;
    logic [7:0] all;
    for (int c = 0; c < `ITD_NCH; c++) begin
      ra = m_ac[c] ? m_act[c] * 32'hA : m_rel[c] * 32'h64;
      if (m_lvl[c] > m_act[c] * 32'h64) m_en[c] = 1;
      else if (m_lvl[c] < ra) m_en[c] = 0;
      if ((m_en[c] ^ m_nc[c]) > m_st[c]) m_cnt[c]++;
      m_st[c] = m_en[c] ^ m_nc[c];
      all[c] = m_st[c][0];
      chk("state", m_st[c], {31'h0, input_channel_n[c]});
      regchk(c, `ITD_OFF_COUNT, m_cnt[c]);
      regchk(c, `ITD_OFF_LEVEL, m_lvl[c]);
      regchk(c, `ITD_OFF_STATE, m_en[c] * 2 + m_st[c]);
    end
    bus(1'b0, `ITD_ADDR_STATES, 32'h0);
    chk("states", {24'h0, all}, rd);
  endtask : check_all

  task print_verdict;
    if (n_fail == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : print_verdict

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (32'h4E20) @(posedge sys_clk);
    n_fail++;
    print_verdict;
  end

  initial begin
    rd = $urandom(32'h282C);
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    for (int c = 0; c < `ITD_NCH; c++) begin
      regchk(c, `ITD_OFF_CTRL, 32'h0);
      regchk(c, `ITD_OFF_ACT_THR, `ITD_ACT_THR_RST);
      regchk(c, `ITD_OFF_REL_THR, `ITD_REL_THR_RST);
      regchk(c, `ITD_OFF_ACT_DLY, `ITD_DLY_RST);
      regchk(c, `ITD_OFF_DROP_DLY, `ITD_DLY_RST);
      m_act[c] = 32'hC8 + $urandom % 32'h5DC;
      m_rel[c] = m_act[c] - 32'h14 - $urandom % 32'h64;
      bus(1'b1, adr(c, `ITD_OFF_ACT_THR), m_act[c]);
      bus(1'b1, adr(c, `ITD_OFF_REL_THR), m_rel[c]);
    end
    regchk(0, 5'h0, 32'h0);
    bus(1'b1, adr(7, `ITD_OFF_ACT_DLY), 32'hFFFF_FFFF);
    regchk(7, `ITD_OFF_ACT_DLY, `ITD_DLY_MAX);
    bus(1'b1, adr(7, `ITD_OFF_ACT_DLY), 32'h0);
    bus(1'b0, 32'h104, 32'h0);
    chk("unmapped", 32'h0, rd);
    // Second pass repeats the level walk with odd channels inverted.
    for (int p = 0; p < 2; p++) begin
      foreach (lv_sel[k]) begin
        for (int c = 0; c < `ITD_NCH; c++) begin
          setv(c, lv_sel[k] == 0 ? hi(c) : lv_sel[k] == 1 ?
               (m_act[c] + m_rel[c]) * 32'h32 : m_rel[c] * 32'h64 - 32'h12C);
        end
        settle(2);
        check_all;
      end
      for (int c = 0; c < `ITD_NCH; c++) begin
        m_nc[c] = c % 2;
        bus(1'b1, adr(c, `ITD_OFF_CTRL), m_nc[c]);
      end
    end
    bus(1'b1, adr(0, `ITD_OFF_ACT_DLY), 32'h32);
    bus(1'b1, adr(0, `ITD_OFF_DROP_DLY), 32'h32);
    setv(0, 32'h0);
    settle(4);
    chk("held high", 32'h1, {31'h0, input_channel_n[0]});
    settle(10);
    check_all;
    // A rise left pending for most of its delay must restart from zero once cancelled.
    setv(0, hi(0));
    settle(8);
    setv(0, 32'h0);
    settle(14);
    check_all;
    setv(0, hi(0));
    settle(5);
    chk("held low", 32'h0, {31'h0, input_channel_n[0]});
    settle(10);
    check_all;
    bus(1'b1, adr(0, `ITD_OFF_DROP_DLY), 32'h0);
    bus(1'b1, adr(0, `ITD_OFF_CTRL), 32'h2);
    m_ac[0] = 1;
    setv(0, m_act[0] * 32'h14);
    settle(10);
    check_all;
    setv(0, m_act[0] * 32'h5);
    settle(3);
    chk("ac stretch", 32'h1, {31'h0, input_channel_n[0]});
    settle(8);
    check_all;
    for (int c = 0; c < `ITD_NCH; c++) begin
      bus(1'b1, adr(c, `ITD_OFF_CTRL), 32'h100 | m_ac[c] * 2 | m_nc[c]);
      m_cnt[c] = 0;
      regchk(c, `ITD_OFF_CTRL, m_ac[c] * 2 | m_nc[c]);
    end
    check_all;
    print_verdict;
  end
endmodule : itd_top_bench
`default_nettype wire
